// ===== logic/rtcc_cfg.svh
`ifndef RTCC_CFG_SVH
`define RTCC_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define RTCC_ADDR_W          3
`define RTCC_ADDR_SECONDS    3'h0
`define RTCC_ADDR_CONTROL    3'h7
`define RTCC_HALT_BIT        7

// ****************************************
// Power-on values, arbitrary by design
// ****************************************
`define RTCC_CTRL_RESET      8'h00
`define RTCC_HALT_RESET      1'b1

// ****************************************
// Divider and calibration cycle
// ****************************************
`define RTCC_LO_W            8
`define RTCC_HI_W            7
`define RTCC_SPLIT_POINT     8'h7F
`define RTCC_TEST_TAP        5
`define RTCC_SEC_LAST        6'h3B
`define RTCC_MIN_W           6
`define RTCC_ELIGIBLE_MIN    6'h3E

`endif

// ===== logic/rtcc_pkg.sv
package rtcc_pkg;

    // Register access from the serial engine
    typedef struct packed {
        logic       we;
        logic       re;
        logic [2:0] addr;
        logic [7:0] wdata;
    } rtcc_req_t;

    // Control register fields, msb first
    typedef struct packed {
        logic       out_level;
        logic       freq_test_enable;
        logic       sign_pos;
        logic [4:0] magnitude;
    } rtcc_ctrl_t;

endpackage

// ===== logic/rtcc_cal.sv
`timescale 1ns/1ns
`include "rtcc_cfg.svh"

// Contract
// - Calibration adds or removes pulses at the divide-by-256 stage, not at the oscillator.
// - The magnitude 0 to 31 sits in bits 4..0 of the control register at address 7.
// - Bit 5 picks the direction, one slows the clock down and zero speeds it up.
// - Correction repeats every 64 minutes, only the first 62 eligible, one second each.
// - An adjusted second is 128 cycles shorter (negative) or 256 cycles longer (positive).
// - For magnitude N exactly the first 2N minutes of each cycle are adjusted, except minute 0 right after reset.
// - With bit 6 set and the oscillator running the pin toggles at 512 Hz.
// - The 512 Hz wave comes from a divider tap that calibration never touches.
// - With bit 6 clear the pin follows bit 7, low when that bit is zero.
// - The pin is open drain, it only pulls low or releases the line.
// - After power-on the oscillator stays stopped whatever the halt bit reads.
// - Control bits have no meaningful power-on value, software writes them first.
// - Bit 7 at address 0 halts the oscillator, clearing it restarts counting.
// - The control register is written and read on its own, apart from the clock block.
module rtcc_cal #(
    // Shrink both to fit minutes in a short simulation
    parameter int HI_W     = `RTCC_HI_W,
    parameter int SEC_LAST = `RTCC_SEC_LAST
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic              osc_clk_pin,
    input  wire rtcc_pkg::rtcc_req_t reg_req,
    output logic [7:0]             reg_rdata,
    output logic                   reg_rvalid,
    output logic                   test_or_level_pin_out,
    output logic                   test_or_level_pin_oe,
    output logic                   osc_running,
    output logic                   sec_pulse,
    output logic                   min_pulse
);

    // ****************************************
    // Registers
    // ****************************************
    rtcc_pkg::rtcc_ctrl_t          ctrl_reg;
    rtcc_pkg::rtcc_ctrl_t          cal_lat_reg;
    logic                          osc_halt_reg;
    logic                          run_reg;
    logic                          osc_s1_reg;
    logic                          osc_s2_reg;
    logic                          osc_s3_reg;
    logic [`RTCC_LO_W-1:0]         lo_reg;
    logic [HI_W-1:0]               hi_reg;
    logic [5:0]                    sec_reg;
    logic [`RTCC_MIN_W-1:0]        min_reg;
    logic                          adj_sec_reg;
    logic                          adj_done_reg;
    logic [7:0]                    rdata_reg;
    logic                          rvalid_reg;
    logic                          pin_oe_reg;
    logic                          sec_pulse_reg;
    logic                          min_pulse_reg;
    logic                          phase_reg;
    logic                          pin_out_reg;

    logic                          osc_tick;
    logic                          lo_wrap;
    logic                          lo_mid;
    logic                          step_pt;
    logic                          alt_pt;
    logic                          adj_active;
    logic                          blank;
    logic                          split;
    logic                          hi_step;
    logic                          sec_end;
    logic                          min_end;
    logic [`RTCC_MIN_W-1:0]        min_next;
    logic [`RTCC_MIN_W-1:0]        span_next;
    logic                          pin_level;
    logic                          wr_ctrl;
    logic                          wr_secs;

    // ****************************************
    // Register writes
    // ****************************************
    // lone control access
    assign wr_ctrl = reg_req.we && (reg_req.addr == `RTCC_ADDR_CONTROL);
    assign wr_secs = reg_req.we && (reg_req.addr == `RTCC_ADDR_SECONDS);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= `RTCC_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= reg_req.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            osc_halt_reg <= `RTCC_HALT_RESET;
        end else if (wr_secs) begin
            osc_halt_reg <= reg_req.wdata[`RTCC_HALT_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            run_reg <= 1'b0;
        end else if (wr_secs) begin
            run_reg <= ~reg_req.wdata[`RTCC_HALT_BIT];
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    // Time fields live elsewhere, so 1..6 read zero here
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_req.re;
            if (reg_req.re) begin
                if (reg_req.addr == `RTCC_ADDR_CONTROL) begin
                    rdata_reg <= ctrl_reg;
                end else if (reg_req.addr == `RTCC_ADDR_SECONDS) begin
                    rdata_reg <= {osc_halt_reg, 7'h00};
                end else begin
                    rdata_reg <= 8'h00;
                end
            end
        end
    end

    // ****************************************
    // Oscillator pin sampling
    // ****************************************
    // Third stage only feeds the edge detect
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
        end else begin
            osc_s1_reg <= osc_clk_pin;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
        end
    end

    assign osc_tick = osc_s2_reg && !osc_s3_reg && run_reg;

    // ****************************************
    // Divide-by-256 stage
    // ****************************************
    // free-running, never corrected
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lo_reg <= '0;
        end else if (osc_tick) begin
            lo_reg <= lo_reg + 1'b1;
        end
    end

    assign lo_wrap    = osc_tick && (lo_reg == '1);
    assign lo_mid     = osc_tick && (lo_reg == `RTCC_SPLIT_POINT);
    assign step_pt    = phase_reg ? lo_mid : lo_wrap;
    assign alt_pt     = phase_reg ? lo_wrap : lo_mid;
    assign adj_active = adj_sec_reg && !adj_done_reg;

    // blank adds 256, split removes 128
    assign blank   = adj_active && cal_lat_reg.sign_pos && step_pt;
    assign split   = adj_active && !cal_lat_reg.sign_pos && alt_pt;
    assign hi_step = (step_pt && !blank) || split;

    // ****************************************
    // Carry phase
    // ****************************************
    // half-cycle carry shift
    // Extra carry alone would cost 256, so the carry point moves instead
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_reg <= 1'b0;
        end else if (split) begin
            phase_reg <= ~phase_reg;
        end
    end

    // ****************************************
    // Seconds stage
    // ****************************************
    assign sec_end = hi_step && (hi_reg == '1);
    assign min_end = sec_end && (sec_reg == `RTCC_MIN_W'(SEC_LAST));

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hi_reg <= '0;
        end else if (hi_step) begin
            hi_reg <= hi_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sec_reg <= 6'h00;
        end else if (min_end) begin
            sec_reg <= 6'h00;
        end else if (sec_end) begin
            sec_reg <= sec_reg + 6'h01;
        end
    end

    // ****************************************
    // Calibration cycle
    // ****************************************
    assign min_next  = min_reg + 1'b1;
    assign span_next = {ctrl_reg.magnitude, 1'b0};

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            min_reg <= '0;
        end else if (min_end) begin
            min_reg <= min_next;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cal_lat_reg <= `RTCC_CTRL_RESET;
        end else if (min_end) begin
            cal_lat_reg <= ctrl_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            adj_sec_reg <= 1'b0;
        end else if (min_end) begin
            adj_sec_reg <= (min_next < span_next) && (min_next < `RTCC_ELIGIBLE_MIN);
        end else if (sec_end) begin
            adj_sec_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            adj_done_reg <= 1'b0;
        end else if (sec_end) begin
            adj_done_reg <= 1'b0;
        end else if (blank || split) begin
            adj_done_reg <= 1'b1;
        end
    end

    // ****************************************
    // Multipurpose pin
    // ****************************************
    // 512 Hz from tap
    assign pin_level = (ctrl_reg.freq_test_enable && run_reg) ?
                       lo_reg[`RTCC_TEST_TAP] : ctrl_reg.out_level;

    // pull low only
    // Never driven high, the pull-up gives the high level
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_out_reg <= 1'b0;
            pin_oe_reg  <= 1'b0;
        end else begin
            pin_out_reg <= 1'b0;
            pin_oe_reg  <= ~pin_level;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sec_pulse_reg <= 1'b0;
            min_pulse_reg <= 1'b0;
        end else begin
            sec_pulse_reg <= sec_end;
            min_pulse_reg <= min_end;
        end
    end

    assign reg_rdata             = rdata_reg;
    assign reg_rvalid            = rvalid_reg;
    assign test_or_level_pin_out = pin_out_reg;
    assign test_or_level_pin_oe  = pin_oe_reg;
    assign osc_running           = run_reg;
    assign sec_pulse             = sec_pulse_reg;
    assign min_pulse             = min_pulse_reg;

endmodule

// ===== sim/rtcc_cal_sva.sv
`timescale 1ns/1ns
// ****
// Checker
// ****
module rtcc_cal_sva (
    input wire logic                clk_sys,
    input wire logic                reset_n,
    input wire rtcc_pkg::rtcc_req_t reg_req,
    input wire logic                reg_rvalid,
    input wire logic                test_or_level_pin_out,
    input wire logic                test_or_level_pin_oe,
    input wire logic                osc_running,
    input wire logic                sec_pulse
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_halt_wr;
        reg_req.we && reg_req.addr == 3'h0;
    endsequence
    sequence s_lvl_wr;
        reg_req.we && reg_req.addr == 3'h7 && !reg_req.wdata[6];
    endsequence
    property p_rd; reg_req.re |=> reg_rvalid; endproperty
    a_rd: assert property (p_rd)
        else $error("read not answered");
    property p_rv; reg_rvalid |-> $past(reg_req.re); endproperty
    a_rv: assert property (p_rv)
        else $error("answer without read");
    property p_od; test_or_level_pin_out == 1'b0; endproperty
    a_od: assert property (p_od)
        else $error("pin driven high");
    property p_stop; s_halt_wr ##0 reg_req.wdata[7] |=> !osc_running; endproperty
    a_stop: assert property (p_stop)
        else $error("halt ignored");
    property p_go; s_halt_wr ##0 !reg_req.wdata[7] |=> osc_running; endproperty
    a_go: assert property (p_go)
        else $error("restart ignored");
    property p_stay;
        !osc_running && !(reg_req.we && reg_req.addr == 3'h0) |=> !osc_running;
    endproperty
    a_stay: assert property (p_stay)
        else $error("started by itself");
    property p_quiet; !osc_running [*2] |-> !sec_pulse; endproperty
    a_quiet: assert property (p_quiet)
        else $error("second while stopped");
    // Level mode seen two edges after the write
    property p_lvl;
        s_lvl_wr ##1 !(reg_req.we && reg_req.addr == 3'h7)
            |=> test_or_level_pin_oe == !$past(reg_req.wdata[7], 2);
    endproperty
    a_lvl: assert property (p_lvl)
        else $error("pin level wrong");
endmodule
bind rtcc_cal rtcc_cal_sva rtcc_cal_sva_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_req(reg_req), .reg_rvalid(reg_rvalid), .test_or_level_pin_out(test_or_level_pin_out),
    .test_or_level_pin_oe(test_or_level_pin_oe), .osc_running(osc_running),
    .sec_pulse(sec_pulse));

// ===== sim/rtcc_cal_tb.sv
`timescale 1ns/1ns
module rtcc_cal_tb;
    localparam int TB_HI_W     = 2;
    localparam int TB_SEC_LAST = 1;
    logic                clk_sys;
    logic                reset_n;
    logic                osc;
    logic                osc_en;
    rtcc_pkg::rtcc_req_t req;
    logic [7:0]          rdata;
    logic                rvalid;
    logic                pin_out;
    logic                pin_oe;
    logic                run;
    logic                sec;
    logic                mn;
    logic [7:0]          v;
    int                  bad_count;
    int                  checks_done;
    int                  cyc = 0;
    int                  n;

    // Four carries a second, two seconds a minute, so minutes fit in the run
    rtcc_cal #(.HI_W(TB_HI_W), .SEC_LAST(TB_SEC_LAST)) rtcc_cal_i (
        .clk_sys(clk_sys), .reset_n(reset_n), .osc_clk_pin(osc),
        .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .test_or_level_pin_out(pin_out), .test_or_level_pin_oe(pin_oe),
        .osc_running(run), .sec_pulse(sec), .min_pulse(mn));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Oscillator at half the clock rate, fastest the sampler can take
    always @(negedge clk_sys) begin
        if (osc_en)
            osc <= ~osc;
    end

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        // Tests need about 17k cycles
        if (cyc == 30000) begin
            bad_count++;
            results();
        end
    end

    // ****
    // Tasks
    // ****
    function automatic int half_clk();
        return 32 * 2;
    endfunction

    // Two clocks per oscillator edge, 256 edges per carry
    function automatic int sec_cycles(int adj);
        return 2 * ((256 << TB_HI_W) + adj);
    endfunction

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(negedge clk_sys);
        req = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(negedge clk_sys);
        req = '0;
    endtask

    task automatic rd(logic [2:0] a, logic [7:0] e);
        @(negedge clk_sys);
        req = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_sys);
        req = '0;
        chk("rvalid", rvalid, 1);
        chk("rdata", rdata, e);
    endtask

    task automatic half(output int c);
        logic p;
        // First edge may be the mode switch
        repeat (3) begin
            p = pin_oe;
            c = 0;
            while (pin_oe === p && c < 500) begin
                @(negedge clk_sys);
                c++;
            end
        end
    endtask

    // Times the second that opens the next minute
    task automatic gap(output int c);
        c = 0;
        while (mn !== 1'b1 && c < 6000) begin
            @(negedge clk_sys);
            c++;
        end
        chk("minute", mn, 1);
        c = 0;
        do begin
            @(negedge clk_sys);
            c++;
        end while (sec !== 1'b1 && c < 6000);
    endtask

    task automatic do_reset();
        reset_n = 1'b0;
        repeat (12) @(negedge clk_sys);
        reset_n = 1'b1;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        reset_n = 1'b0;
        req = '0;
        osc = 1'b0;
        osc_en = 1'b0;
        v = 8'($urandom(42405));
        do_reset();
        rd(3'h7, 8'h00);
        rd(3'h0, 8'h80);
        chk("run", run, 0);
        for (int k = 0; k < 8; k++) begin
            v = (k == 0) ? 8'h80 : (k == 1) ? 8'h7F : 8'($urandom);
            wr(3'h7, v);
            wr(3'h3, ~v);
            rd(3'h7, v);
            rd(3'h3, 8'h00);
            chk("level", pin_oe, !v[7]);
        end
        wr(3'h0, 8'h00);
        @(negedge clk_sys);
        chk("run", run, 1);
        osc_en = 1'b1;
        wr(3'h7, 8'h40);
        half(n);
        chk("half", n, half_clk());
        wr(3'h7, 8'h7F);
        half(n);
        chk("half", n, half_clk());
        wr(3'h0, 8'h80);
        @(negedge clk_sys);
        chk("run", run, 0);
        chk("stopped", pin_oe, 1);
        // Minute 0 uses the value latched at reset, so no adjustment yet
        osc_en = 1'b0;
        do_reset();
        wr(3'h7, 8'h21);
        wr(3'h0, 8'h00);
        osc_en = 1'b1;
        n = 0;
        while (sec !== 1'b1 && n < 6000) begin
            @(negedge clk_sys);
            n++;
        end
        chk("second", n >= sec_cycles(0) && n <= sec_cycles(0) + 8, 1);
        gap(n);
        chk("long", n, sec_cycles(256));
        gap(n);
        chk("past 2N", n, sec_cycles(0));
        // Negative sign, one step: minute 1 opens with a short second
        osc_en = 1'b0;
        do_reset();
        wr(3'h7, 8'h01);
        wr(3'h0, 8'h00);
        osc_en = 1'b1;
        gap(n);
        chk("short", n, sec_cycles(-128));
        results();
    end
endmodule
